// *** logic/cfg_wake_defines.svh ***
// offsets, field resets and timing counts for the wake-up option control
// assumes a 40 MHz mclk and a byte-addressed Avalon-MM register port
// Summary of operation
// - master mode drives the config clock out, starting at 2.5 MHz.
// - after frequency bits load, master clock switches to the selected rate.
// - with external done on, wake-up waits for done pin high per tick.
// - with external done off, wake starts on done bit, pin ignored.
// - external done off: sequences 1 to 25, default sequence 21.
// - external done on: sequences 1 to 7, default sequence 4.
// - either overflow option forces external done on, default sequence 4.
// - sampled mode pins select the config port; overflow options reset off.
// - done pin held low until config completes cleanly and wake is ready.
// - done pin open drain by default; forced open drain with external done.
// - wake sequencer steps done and three global controls through phases.
// - wait-for-lock option holds wake-up until all selected PLLs lock.
// - wake clock is external (config clock or test clock) or user clock.
// - security on refuses read-back on both ports; off allows it.
// - user code area stays readable whatever the security setting.
// - compression on feeds the decompression engine; off loads direct.
// - keep-pins on (default) keeps config pins reserved after wake-up.
// - each sequence maps done and three controls onto phases T0 to T3.
`ifndef CFG_WAKE_DEFINES_SVH
`define CFG_WAKE_DEFINES_SVH

// register byte offsets
`define CW_ADDR_CTRL 5'h00
`define CW_ADDR_WAKE 5'h04
`define CW_ADDR_MCLK 5'h08
`define CW_ADDR_PLL 5'h0C
`define CW_ADDR_STAT 5'h10

// reset values
`define CW_CTRL_RST 9'h003
`define CW_PLL_SEL_RST 4'hF

// wake-up sequence selection
`define CW_SEQ_DEF_INT 5'h15
`define CW_SEQ_MAX_INT 5'h19
`define CW_SEQ_DEF_EXT 5'h04
`define CW_SEQ_MAX_EXT 5'h07
`define CW_PH_LAST 2'h3

// configuration mode pin codes that select a master mode
`define CW_MODE_MSER 3'h0
`define CW_MODE_MPAR 3'h2

// master clock timing
`define CW_CLK_HZ 40000000
`define CW_MCCLK_DEF_HZ 2500000
`define CW_MCCLK_HALF 4'((`CW_CLK_HZ) / (2 * `CW_MCCLK_DEF_HZ))
`define CW_MCCLK_SEL_MAX 3'h3

`define CW_NUM_PLL 4

`endif

// *** logic/cfg_wake_pkg.sv ***
// types shared by the wake-up option control and its phase table
// assumes nothing beyond a SystemVerilog compiler
package cfg_wake_pkg;

	// sequencer progress from configuration to user mode
	typedef enum logic [1:0] {ST_CFG, ST_WAIT, ST_PHASE, ST_USER} wake_state_t;

	// phase index at which each output takes its user-mode level
	typedef struct packed {
		logic [1:0] done;
		logic [1:0] oe;
		logic [1:0] wd;
		logic [1:0] sr;
	} wake_phase_t;

	// control register, bit 0 is keep_pins
	typedef struct packed {
		logic ovf_flow;
		logic ovf_bypass;
		logic decompress;
		logic readback_lock;
		logic user_wake_clk;
		logic wake_on_lock;
		logic ext_done;
		logic done_open_drain_opt;
		logic keep_pins;
	} cfg_opts_t;

	// status register, bit 0 is done_hi
	typedef struct packed {
		logic [2:0] cfg_mode;
		logic user_mode;
		logic freq_loaded;
		logic od_eff;
		logic ext_eff;
		logic [4:0] seq;
		logic [1:0] state;
		logic [1:0] phase;
		logic sr_rel;
		logic wd_rel;
		logic oe;
		logic done_hi;
	} wake_status_t;

endpackage : cfg_wake_pkg

// *** logic/wake_seq_table.sv ***
// phase table: wake-up sequence number to per-output phase index
// assumes the caller has already clamped the number into 1..25
`timescale 1ns/10ps
module wake_seq_table
	import cfg_wake_pkg::*;
(
	input wire logic [4:0] seq,
	output wake_phase_t phases
);

	// packed as done, out enable, write disable, set/reset
	always_comb begin
		case (seq)
			5'h01: phases = 8'h15;
			5'h02: phases = 8'h2A;
			5'h03: phases = 8'h3F;
			5'h04: phases = 8'h1A;
			5'h05: phases = 8'h1F;
			5'h06: phases = 8'h1B;
			5'h07: phases = 8'h1E;
			5'h08: phases = 8'h6A;
			5'h09: phases = 8'h7F;
			5'h0A: phases = 8'h7A;
			5'h0B: phases = 8'h6F;
			5'h0C: phases = 8'hBF;
			5'h0D: phases = 8'h95;
			5'h0E: phases = 8'h9F;
			5'h0F: phases = 8'h97;
			5'h10: phases = 8'hB7;
			5'h11: phases = 8'hB5;
			5'h12: phases = 8'h9D;
			5'h13: phases = 8'hEA;
			5'h14: phases = 8'hD5;
			5'h16: phases = 8'hD6;
			5'h17: phases = 8'hE6;
			5'h18: phases = 8'hE5;
			5'h19: phases = 8'hD9;
			default: phases = 8'hDA; // sequence 21
		endcase
	end

endmodule : wake_seq_table

// *** logic/cfg_wake_ctrl.sv ***
// end-of-configuration control: master clock, done pin, wake-up sequencer
// assumes loader strobes on mclk; pins and PLL locks arrive asynchronously
//
// The Avalon-MM slave port and the address map were left to the implementer.
`include "cfg_wake_defines.svh"
`timescale 1ns/10ps
module cfg_wake_ctrl
	import cfg_wake_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [2:0] cfg_mode_pin,
	input wire logic config_clock_sense,
	output logic config_clock_pin,
	output logic config_clock_pin_en,
	input wire logic tck_pin,
	input wire logic user_clk_pin,
	input wire logic done_pin_level,
	output logic done_pin_drive,
	output logic done_pin_en,
	input wire logic [`CW_NUM_PLL-1:0] pll_lock,
	input wire logic cfg_restart,
	input wire logic cfg_done_bit,
	input wire logic cfg_error,
	input wire logic jtag_method,
	input wire logic readback_req_port,
	input wire logic readback_req_jtag,
	input wire logic usercode_req,
	output logic readback_grant,
	output logic readback_deny,
	input wire logic [7:0] stream_data,
	input wire logic stream_valid,
	output logic [7:0] stream_out_data,
	output logic to_engine_valid,
	output logic to_direct_valid,
	output logic global_output_enable,
	output logic global_write_disable,
	output logic global_set_reset,
	output logic cfg_pins_reserved,
	output logic [2:0] config_port_mode,
	output logic master_mode
);

	localparam int SW = `CW_NUM_PLL + 7;

	cfg_opts_t opts_r;
	logic [4:0] seq_sel_r;
	logic [2:0] freq_sel_r;
	logic freq_loaded_r;
	logic [`CW_NUM_PLL-1:0] pll_sel_r;
	logic ack_r;
	logic acc;
	logic wr_en;
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	logic [`CW_NUM_PLL-1:0] pll_s;
	logic [2:0] mode_s;
	logic done_s;
	logic tck_s;
	logic uclk_s;
	logic cfg_clk_s;
	logic [1:0] samp_cnt_r;
	logic [2:0] sel_c;
	logic [3:0] half_cyc;
	logic [3:0] div_cnt_r;
	logic cfg_clk_r;
	logic wclk_lvl;
	logic wclk_d_r;
	logic wake_tick;
	logic ext_eff;
	logic od_eff;
	logic [4:0] seq_eff;
	wake_phase_t ph;
	logic locks_ok;
	logic start_ok;
	wake_state_t st_r;
	logic [1:0] phase_r;
	logic active;
	logic done_hi;
	wake_status_t stat;

	// two-stage synchronisers for every pin and lock input
	always_ff @(posedge mclk) begin
		if (reset) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {pll_lock, cfg_mode_pin, done_pin_level, tck_pin,
				user_clk_pin, config_clock_sense};
			sync2_r <= sync1_r;
		end
	end
	assign {pll_s, mode_s, done_s, tck_s, uclk_s, cfg_clk_s} = sync2_r;

	// mode pins sampled once the synchronisers have filled after a restart
	always_ff @(posedge mclk) begin
		if (reset || cfg_restart) begin
			samp_cnt_r <= 2'h3;
		end else if (samp_cnt_r != 2'h0) begin
			samp_cnt_r <= samp_cnt_r - 2'h1;
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			config_port_mode <= 3'h0;
			master_mode <= 1'h0;
		end else if (samp_cnt_r == 2'h1) begin
			config_port_mode <= mode_s;
			master_mode <= (mode_s == `CW_MODE_MSER) ||
				(mode_s == `CW_MODE_MPAR);
		end
	end

	// master clock divider: default rate until the frequency bits load
	assign sel_c = (freq_sel_r > `CW_MCCLK_SEL_MAX) ? `CW_MCCLK_SEL_MAX :
		freq_sel_r;
	assign half_cyc = freq_loaded_r ? (`CW_MCCLK_HALF >> sel_c) :
		`CW_MCCLK_HALF;
	always_ff @(posedge mclk) begin
		if (reset || !master_mode) begin
			div_cnt_r <= 4'h0;
			cfg_clk_r <= 1'h0;
		end else if (div_cnt_r >= half_cyc - 4'h1) begin
			div_cnt_r <= 4'h0;
			cfg_clk_r <= ~cfg_clk_r;
		end else begin
			div_cnt_r <= div_cnt_r + 4'h1;
		end
	end
	assign config_clock_pin = cfg_clk_r;
	assign config_clock_pin_en = master_mode;

	// wake clock choice and its rising-edge tick
	always_comb begin
		if (opts_r.user_wake_clk) begin
			wclk_lvl = uclk_s;
		end else if (jtag_method) begin
			wclk_lvl = tck_s;
		end else if (master_mode) begin
			wclk_lvl = cfg_clk_r;
		end else begin
			wclk_lvl = cfg_clk_s;
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			wclk_d_r <= 1'h0;
		end else begin
			wclk_d_r <= wclk_lvl;
		end
	end
	assign wake_tick = wclk_lvl & ~wclk_d_r;

	// effective options after overflow forcing and sequence clamping
	assign ext_eff = opts_r.ext_done | opts_r.ovf_bypass | opts_r.ovf_flow;
	assign od_eff = opts_r.done_open_drain_opt | ext_eff;
	always_comb begin
		if (ext_eff) begin
			seq_eff = (seq_sel_r == 5'h00 || seq_sel_r > `CW_SEQ_MAX_EXT) ?
				`CW_SEQ_DEF_EXT : seq_sel_r;
		end else begin
			seq_eff = (seq_sel_r == 5'h00 || seq_sel_r > `CW_SEQ_MAX_INT) ?
				`CW_SEQ_DEF_INT : seq_sel_r;
		end
	end

	wake_seq_table u_table (
		.seq(seq_eff),
		.phases(ph)
	);

	// start condition: locks, then the done pin if it is honoured
	assign locks_ok = ~opts_r.wake_on_lock | (&(pll_s | ~pll_sel_r));
	assign start_ok = locks_ok & (~ext_eff | done_s);

	// wake-up sequencer
	always_ff @(posedge mclk) begin
		if (reset || cfg_restart) begin
			st_r <= ST_CFG;
			phase_r <= 2'h0;
		end else begin
			case (st_r)
				ST_CFG: begin
					if (cfg_done_bit && !cfg_error) begin
						st_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (wake_tick && start_ok) begin
						st_r <= ST_PHASE;
						phase_r <= 2'h0;
					end
				end
				ST_PHASE: begin
					if (wake_tick) begin
						if (phase_r == `CW_PH_LAST) begin
							st_r <= ST_USER;
						end else begin
							phase_r <= phase_r + 2'h1;
						end
					end
				end
				ST_USER: begin
					st_r <= ST_USER;
				end
				default: begin
					st_r <= ST_CFG;
				end
			endcase
		end
	end

	// done is released while awaiting the external level so it can rise
	assign active = (st_r == ST_PHASE) || (st_r == ST_USER);
	assign done_hi = (active && phase_r >= ph.done) ||
		(ext_eff && st_r == ST_WAIT);

	// pin and global control outputs
	always_ff @(posedge mclk) begin
		if (reset) begin
			done_pin_drive <= 1'h0;
			done_pin_en <= 1'h1;
			global_output_enable <= 1'h0;
			global_write_disable <= 1'h1;
			global_set_reset <= 1'h1;
			cfg_pins_reserved <= 1'h1;
		end else begin
			done_pin_en <= od_eff ? ~done_hi : 1'h1;
			done_pin_drive <= od_eff ? 1'h0 : done_hi;
			global_output_enable <= active && phase_r >= ph.oe;
			global_write_disable <= !(active && phase_r >= ph.wd);
			global_set_reset <= !(active && phase_r >= ph.sr);
			cfg_pins_reserved <= (st_r != ST_USER) || opts_r.keep_pins;
		end
	end

	// read-back gate and bitstream routing
	always_ff @(posedge mclk) begin
		if (reset) begin
			readback_grant <= 1'h0;
			readback_deny <= 1'h0;
			stream_out_data <= 8'h00;
			to_engine_valid <= 1'h0;
			to_direct_valid <= 1'h0;
		end else begin
			readback_grant <= usercode_req | ((readback_req_port |
				readback_req_jtag) & ~opts_r.readback_lock);
			readback_deny <= (readback_req_port | readback_req_jtag) &
				opts_r.readback_lock & ~usercode_req;
			stream_out_data <= stream_data;
			to_engine_valid <= stream_valid & opts_r.decompress;
			to_direct_valid <= stream_valid & ~opts_r.decompress;
		end
	end

	// bus handshake: one wait cycle, then acknowledge
	assign acc = read | write;
	assign waitrequest = acc & ~ack_r;
	assign wr_en = write & ack_r;
	always_ff @(posedge mclk) begin
		if (reset) begin
			ack_r <= 1'h0;
		end else begin
			ack_r <= acc & ~ack_r;
		end
	end

	// register writes; a frequency write marks the bits as loaded
	always_ff @(posedge mclk) begin
		if (reset) begin
			opts_r <= `CW_CTRL_RST;
			seq_sel_r <= 5'h00;
			freq_sel_r <= 3'h0;
			freq_loaded_r <= 1'h0;
			pll_sel_r <= `CW_PLL_SEL_RST;
		end else begin
			if (cfg_restart) begin
				freq_loaded_r <= 1'h0;
			end
			if (wr_en) begin
				case (address)
					`CW_ADDR_CTRL: begin
						if (byteenable[0]) begin
							opts_r[7:0] <= writedata[7:0];
						end
						if (byteenable[1]) begin
							opts_r[8] <= writedata[8];
						end
					end
					`CW_ADDR_WAKE: begin
						if (byteenable[0]) begin
							seq_sel_r <= writedata[4:0];
						end
					end
					`CW_ADDR_MCLK: begin
						if (byteenable[0]) begin
							freq_sel_r <= writedata[2:0];
							freq_loaded_r <= 1'h1;
						end
					end
					`CW_ADDR_PLL: begin
						if (byteenable[0]) begin
							pll_sel_r <= writedata[`CW_NUM_PLL-1:0];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// read data registered in the wait cycle
	assign stat = {config_port_mode, st_r == ST_USER, freq_loaded_r, od_eff,
		ext_eff, seq_eff, st_r, phase_r, ~global_set_reset,
		~global_write_disable, global_output_enable, done_hi};
	always_ff @(posedge mclk) begin
		if (reset) begin
			readdata <= 32'h0;
		end else if (read && !ack_r) begin
			case (address)
				`CW_ADDR_CTRL: readdata <= {23'h0, opts_r};
				`CW_ADDR_WAKE: readdata <= {27'h0, seq_sel_r};
				`CW_ADDR_MCLK: readdata <= {29'h0, freq_sel_r};
				`CW_ADDR_PLL: readdata <= {28'h0, pll_sel_r};
				`CW_ADDR_STAT: readdata <= {12'h0, stat};
				default: readdata <= 32'h0;
			endcase
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_wake_go;
		st_r == ST_WAIT && wake_tick && start_ok && !cfg_restart;
	endsequence
	sequence s_enter_t0;
		st_r == ST_PHASE && phase_r == 2'h0;
	endsequence

	a_wake_start_t0:
		assert property (s_wake_go |=> s_enter_t0)
		else $error("wake start did not enter phase T0");
	a_phase_step_one:
		assert property ((st_r == ST_PHASE && wake_tick && phase_r != 2'h3 &&
			!cfg_restart) |=> phase_r == $past(phase_r) + 2'h1)
		else $error("phase did not advance by one");
	a_phase_hold:
		assert property ((active && !wake_tick && !cfg_restart) |=>
			$stable(phase_r) && active)
		else $error("phase moved without a wake tick");
	a_ext_done_hold:
		assert property ((st_r == ST_WAIT && ext_eff && !done_s &&
			!cfg_restart) |=> st_r == ST_WAIT)
		else $error("wake started with done pin low");
	a_int_done_go:
		assert property ((st_r == ST_WAIT && !ext_eff && locks_ok &&
			wake_tick && !cfg_restart) |=> st_r == ST_PHASE)
		else $error("internal done wake did not start");
	a_lock_hold:
		assert property ((st_r == ST_WAIT && !locks_ok && !cfg_restart) |=>
			st_r == ST_WAIT)
		else $error("wake started without PLL lock");
	a_seq_default_int:
		assert property ((!ext_eff && seq_sel_r == 5'h00) |->
			seq_eff == 5'h15)
		else $error("default sequence is not 21");
	a_seq_range_ext:
		assert property (ext_eff |-> seq_eff >= 5'h01 && seq_eff <= 5'h07 &&
			(seq_sel_r != 5'h00 || seq_eff == 5'h04))
		else $error("external done sequence out of range");
	a_ovf_forces:
		assert property ((opts_r.ovf_bypass || opts_r.ovf_flow) |->
			ext_eff && od_eff)
		else $error("overflow did not force external done");
	a_done_low_cfg:
		assert property (st_r == ST_CFG |=> done_pin_en && !done_pin_drive)
		else $error("done pin not low during configuration");
	a_done_open_drain_opt_forced:
		assert property (ext_eff |=> !(done_pin_en && done_pin_drive))
		else $error("done pin driven high with external done");
	a_readback_lock:
		assert property ((opts_r.readback_lock && readback_req_port &&
			!usercode_req) |=> readback_deny && !readback_grant)
		else $error("locked read-back was granted");
	a_usercode_open:
		assert property (usercode_req |=> readback_grant)
		else $error("user code read was refused");
	a_mclk_default:
		assert property (($changed(cfg_clk_r) && master_mode &&
			!freq_loaded_r) |=> ($stable(cfg_clk_r) || freq_loaded_r ||
			!master_mode) [*7])
		else $error("default master clock half period is not 8");
	a_keep_pins:
		assert property ((st_r == ST_USER && opts_r.keep_pins) |=>
			cfg_pins_reserved)
		else $error("config pins released with keep option on");

endmodule : cfg_wake_ctrl

// *** dv/cfg_host_model.sv ***
// model of the configuration host and the chained devices on done
// assumes the device drives done as en/drive and owns the clock in master mode
`timescale 1ns/10ps
module cfg_host_model (
	input wire logic done_pin_drive,
	input wire logic done_pin_en,
	input wire logic hold_low,
	input wire logic config_clock_pin,
	input wire logic config_clock_pin_en,
	output logic done_pin_level,
	output logic config_clock_sense
);
	// wired done line with pull-up; peers only ever pull it low
	assign done_pin_level = !(done_pin_en && !done_pin_drive) &&
		!hold_low;
	// clock line follows the device in master mode, else the pull-up
	assign config_clock_sense = config_clock_pin_en ? config_clock_pin : 1'b1;
endmodule : cfg_host_model

// *** dv/test_config_wakeup_option_control.sv ***
// self-checking bench for the wake-up option control
// assumes logic/ and dv/cfg_host_model.sv are compiled first
`include "cfg_wake_defines.svh"
`timescale 1ns/10ps
module test_config_wakeup_option_control;
	import cfg_wake_pkg::*;
	localparam int TICK = 2; // master clock period in mclk at select 3
	logic mclk, reset, read, write, readback_req_port, readback_req_jtag;
	logic usercode_req, readback_grant, readback_deny, stream_valid;
	logic [4:0] address;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable, pll_lock;
	logic [2:0] cfg_mode_pin, config_port_mode;
	logic [7:0] stream_data, stream_out_data;
	logic waitrequest, config_clock_sense, config_clock_pin, tck_pin;
	logic config_clock_pin_en, user_clk_pin, done_pin_level, done_pin_drive;
	logic done_pin_en, cfg_restart, cfg_done_bit, cfg_error, jtag_method;
	logic to_engine_valid, to_direct_valid, global_output_enable, hold_low;
	logic global_write_disable, global_set_reset, cfg_pins_reserved;
	logic master_mode;
	int fail_count, n_checks, cyc;
	int tw [4]; // cycle at which done, oe, wd and sr reach user level
	// phase of {done, oe, wd, sr} for each sequence, entry 0 is the default
	logic [7:0] ph_tab [26] = '{8'hDA, 8'h15, 8'h2A, 8'h3F, 8'h1A, 8'h1F,
		8'h1B, 8'h1E, 8'h6A, 8'h7F, 8'h7A, 8'h6F, 8'hBF, 8'h95, 8'h9F, 8'h97,
		8'hB7, 8'hB5, 8'h9D, 8'hEA, 8'hD5, 8'hDA, 8'hD6, 8'hE6, 8'hE5, 8'hD9};

	cfg_wake_ctrl u_cfg_wake_ctrl (.mclk, .reset, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .cfg_mode_pin,
		.config_clock_sense, .config_clock_pin, .config_clock_pin_en, .tck_pin,
		.user_clk_pin, .done_pin_level, .done_pin_drive, .done_pin_en,
		.pll_lock, .cfg_restart, .cfg_done_bit, .cfg_error, .jtag_method,
		.readback_req_port, .readback_req_jtag, .usercode_req, .readback_grant,
		.readback_deny, .stream_data, .stream_valid, .stream_out_data,
		.to_engine_valid, .to_direct_valid, .global_output_enable,
		.global_write_disable, .global_set_reset, .cfg_pins_reserved,
		.config_port_mode, .master_mode);
	cfg_host_model u_cfg_host_model (.done_pin_drive, .done_pin_en, .hold_low,
		.config_clock_pin, .config_clock_pin_en, .done_pin_level,
		.config_clock_sense);

	// clock and cycle count
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;
	// free-running user clock (period 4) and test clock (period 8)
	always @(posedge mclk) {tck_pin, user_clk_pin} <= {cyc[2], cyc[1]};

	task automatic print_verdict;
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic hang;
		fail_count++;
		print_verdict();
	endtask : hang

	// one avalon access: hold until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int i;
		logic wt;
		wt = 1'b1;
		@(posedge mclk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		for (i = 0; i < 50 && wt !== 1'b0; i++) begin
			@(posedge mclk);
			wt = waitrequest;
			q = readdata;
		end
		if (wt !== 1'b0)
			hang();
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic stat(output wake_status_t st);
		logic [31:0] x;
		bus(1'b0, `CW_ADDR_STAT, 32'h0, x);
		st = x[19:0];
	endtask : stat

	function automatic int ph(int s, int j);
		return ph_tab[s][7-2*j -: 2];
	endfunction : ph

	// restart, program options and a fast master clock, then finish loading
	task automatic start(input logic [8:0] ctrl, input logic [4:0] seq);
		@(posedge mclk);
		cfg_done_bit <= 1'b0;
		cfg_restart <= 1'b1;
		@(posedge mclk);
		cfg_restart <= 1'b0;
		wr(`CW_ADDR_CTRL, {23'h0, ctrl});
		wr(`CW_ADDR_WAKE, {27'h0, seq});
		wr(`CW_ADDR_MCLK, 32'h3);
		@(posedge mclk);
		cfg_done_bit <= 1'b1;
	endtask : start

	// cycle at which done, oe, wd and sr each reach their user level
	task automatic run_wake;
		int i, j;
		logic [3:0] seen, v;
		seen = 4'h0;
		for (i = 0; i < 400 && seen !== 4'hF; i++) begin
			@(negedge mclk);
			v = {!(done_pin_en && !done_pin_drive), global_output_enable,
				!global_write_disable, !global_set_reset};
			for (j = 0; j < 4; j++)
				if (v[3-j] === 1'b1 && !seen[j]) begin
					seen[j] = 1'b1;
					tw[j] = cyc;
				end
		end
		if (seen !== 4'hF)
			hang();
		repeat (12) @(posedge mclk);
	endtask : run_wake

	task automatic half(output int n);
		int i;
		for (i = 0; i < 99 && config_clock_pin !== 1'b0; i++) @(negedge mclk);
		if (i == 99)
			hang();
		for (i = 0; i < 99 && config_clock_pin !== 1'b1; i++) @(negedge mclk);
		if (i == 99)
			hang();
		for (n = 0; n < 99 && config_clock_pin === 1'b1; n++) @(negedge mclk);
		if (n == 99)
			hang();
	endtask : half

	task automatic t_reset;
		logic [31:0] x;
		wake_status_t st;
		chk({global_output_enable, global_write_disable, global_set_reset,
			cfg_pins_reserved, done_pin_en, done_pin_drive}, 6'h1E);
		bus(1'b0, `CW_ADDR_CTRL, 32'h0, x);
		chk(x, 32'h003);
		bus(1'b0, `CW_ADDR_PLL, 32'h0, x);
		chk(x, 32'hF);
		wr(5'h14, 32'hFFFF);
		bus(1'b0, 5'h14, 32'h0, x);
		chk(x, 32'h0);
		stat(st);
		chk({st.od_eff, st.ext_eff, st.seq}, 7'h55);
	endtask : t_reset

	task automatic t_mclk;
		int n;
		chk({master_mode, config_clock_pin_en, config_port_mode}, 5'h18);
		half(n);
		chk(n, 8);
		wr(`CW_ADDR_MCLK, 32'h1);
		half(n);
		half(n);
		chk(n, 4);
		cfg_mode_pin <= 3'h1;
		start(9'h003, 5'h0);
		repeat (10) @(posedge mclk);
		chk({master_mode, config_clock_pin_en, config_port_mode}, 5'h01);
		cfg_mode_pin <= 3'h0;
	endtask : t_mclk

	// every sequence with the line held low by a peer, which is ignored
	task automatic t_table;
		int s, j;
		wake_status_t st;
		hold_low <= 1'b1;
		for (s = 0; s < 26; s++) begin
			start(9'h003, 5'(s));
			run_wake();
			for (j = 1; j < 4; j++)
				chk(tw[j] - tw[0], TICK * (ph(s, j) - ph(s, 0)));
		end
		stat(st);
		chk({st.state, st.seq, st.user_mode}, 8'hF3);
	endtask : t_table

	task automatic t_ext;
		wake_status_t st;
		start(9'h004, 5'h09);
		repeat (40) @(posedge mclk);
		stat(st);
		chk({st.state, global_output_enable}, 3'h2);
		chk(st.seq, 5'h04);
		chk({st.od_eff, done_pin_en}, 2'h2);
		hold_low <= 1'b0;
		run_wake();
		chk(tw[2] - tw[1], TICK);
		chk(cfg_pins_reserved, 1'b0);
	endtask : t_ext

	task automatic t_ovf;
		int k;
		wake_status_t st;
		hold_low <= 1'b1;
		for (k = 0; k < 2; k++) begin
			start(k ? 9'h103 : 9'h083, 5'h00);
			repeat (40) @(posedge mclk);
			stat(st);
			chk({st.ext_eff, st.seq, global_output_enable}, 7'h48);
		end
		hold_low <= 1'b0;
	endtask : t_ovf

	task automatic t_err;
		wake_status_t st;
		cfg_error <= 1'b1;
		start(9'h003, 5'h00);
		repeat (40) @(posedge mclk);
		stat(st);
		chk({st.state, done_pin_en, done_pin_drive}, 4'h2);
		cfg_error <= 1'b0;
	endtask : t_err

	task automatic t_lock;
		pll_lock <= 4'hA;
		wr(`CW_ADDR_PLL, 32'h5);
		start(9'h009, 5'h00);
		repeat (40) @(posedge mclk);
		chk(global_output_enable, 1'b0);
		pll_lock <= 4'h5;
		run_wake();
		chk(tw[0] - tw[1], 2 * TICK);
		chk({done_pin_en, done_pin_drive}, 2'h3);
	endtask : t_lock

	// wake-up stepped by the user clock, then by the test clock
	task automatic t_wclk;
		start(9'h013, 5'h01);
		run_wake();
		chk(tw[1] - tw[0], 4);
		jtag_method <= 1'b1;
		start(9'h003, 5'h01);
		run_wake();
		chk(tw[1] - tw[0], 8);
		jtag_method <= 1'b0;
	endtask : t_wclk

	// read-back requests and a stream byte under both option settings
	task automatic t_rb;
		int k, r;
		logic [2:0] q;
		for (k = 0; k < 2; k++) begin
			wr(`CW_ADDR_CTRL, {25'h0, k[0], k[0], 5'h03});
			for (r = 0; r < 3; r++) begin
				q = 3'b001 << r;
				@(posedge mclk);
				{usercode_req, readback_req_jtag, readback_req_port} <= q;
				stream_data <= 8'hA5 ^ 8'(r);
				stream_valid <= 1'b1;
				@(posedge mclk);
				{usercode_req, readback_req_jtag, readback_req_port} <= 3'h0;
				stream_valid <= 1'b0;
				@(negedge mclk);
				chk(readback_grant, !k || q[2]);
				chk(readback_deny, k && !q[2]);
				chk({to_engine_valid, to_direct_valid, stream_out_data},
					{k[0], !k[0], 8'hA5 ^ 8'(r)});
			end
		end
	endtask : t_rb

	// reset, then the scenarios in turn
	initial begin
		{reset, byteenable} = 5'h1F;
		{read, write, address, writedata} = '0;
		{cfg_mode_pin, pll_lock, hold_low} = '0;
		{cfg_restart, cfg_done_bit, cfg_error, jtag_method} = '0;
		{readback_req_port, readback_req_jtag, usercode_req} = '0;
		{stream_data, stream_valid} = '0;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		repeat (6) @(posedge mclk);
		t_reset();
		t_mclk();
		t_table();
		t_ext();
		t_ovf();
		t_err();
		t_lock();
		t_wclk();
		t_rb();
		print_verdict();
	end
endmodule : test_config_wakeup_option_control
